// >>> hdl/edid_pkg.sv
// Constants for the edge interrupt and diagnostic block
package edid_pkg;
    localparam int NUM_CH = 2;
    localparam int CLK_HZ = 25_000_000;
    localparam int US_PER_S = 1_000_000;
    localparam int TICK_US = 1;
    localparam int TICK_CYC = (CLK_HZ / US_PER_S) * TICK_US;

    // Record numbers on the backplane access port
    localparam logic [7:0] REC_DIAG_IRQ_ENABLE = 8'h00;
    localparam logic [7:0] REC_EDGE_EN = 8'h80;
    localparam logic [7:0] REC_DIAG_SHORT = 8'h00;
    localparam logic [7:0] REC_DIAG_FULL = 8'h01;
    localparam logic [7:0] REC_PIRQ = 8'h02;
    localparam logic [4:0] IDX_RISE_EN = 5'h00;
    localparam logic [4:0] IDX_FALL_EN = 5'h01;

    // Record lengths in bytes
    localparam logic [4:0] LEN_DIAG_SHORT = 5'h04;
    localparam logic [4:0] LEN_DIAG_FULL = 5'h14;
    localparam logic [4:0] LEN_PIRQ = 5'h04;

    // Byte positions in the diagnostic record
    localparam logic [4:0] DB_FLAGS_PRI = 5'h00;
    localparam logic [4:0] DB_MOD_INFO = 5'h01;
    localparam logic [4:0] DB_RSVD = 5'h02;
    localparam logic [4:0] DB_FLAGS_SEC = 5'h03;
    localparam logic [4:0] DB_CH_KIND = 5'h04;
    localparam logic [4:0] DB_BITS_PER_CH = 5'h05;
    localparam logic [4:0] DB_CH_COUNT = 5'h06;
    localparam logic [4:0] DB_LOST = 5'h07;
    localparam logic [4:0] DB_TS = 5'h10;

    // Byte positions in the process interrupt record
    localparam logic [4:0] PB_EDGES = 5'h00;
    localparam logic [4:0] PB_LEVELS = 5'h01;
    localparam logic [4:0] PB_TS_HI = 5'h02;
    localparam logic [4:0] PB_TS_LO = 5'h03;

    // Field positions
    localparam int FP_MOD_FAIL = 0;
    localparam int FP_EXT_ERR = 2;
    localparam int FP_CH_ERR = 3;
    localparam int FS_BUF_OVF = 3;
    localparam int FS_PIRQ_LOST = 6;

    // Fixed and reset values
    localparam logic [7:0] DIAG_IRQ_ENABLE_ON = 8'h40;
    localparam logic [7:0] DIAG_IRQ_ENABLE_RST = 8'h00;
    localparam logic [7:0] EDGE_EN_RST = 8'h00;
    localparam logic [7:0] MOD_INFO_VAL = 8'h1F;
    localparam logic [7:0] CH_KIND_VAL = 8'h70;
    localparam logic [7:0] BITS_PER_CH_VAL = 8'h00;
    localparam logic [7:0] CH_COUNT_VAL = 8'h02;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
endpackage : edid_pkg

// >>> hdl/edid_top.sv
// Edge process interrupt and diagnostic record logic, two inputs
//
// Behaviour
// - Process interrupt on an input edge only if that direction is enabled.
// - Falling enable byte: bit 0 input zero, bit 1 input one.
// - Edge flag byte: bit 0 edge on input zero, bit 1 input one.
// - Record holds input levels at interrupt time in bits 0 and 1.
// - Record holds ticker low 16 bits, high byte first.
// - 32-bit microsecond ticker from zero at reset, wraps at maximum.
// - Diagnostic buffer overflow raises unmaskable interrupt, sets secondary bit 3.
// - Lost process interrupt raises diagnostic interrupt, sets secondary bit 6.
// - Going event issued by itself once the incoming cause ends.
// - Events between incoming and going are discarded, not queued.
// - Fault indicator lit from first incoming until last going.
// - Primary flags: bit 0 module failure, 2 external, 3 channel error.
// - Module info byte reads 1Fh: digital class, channel info present.
// - Channel kind byte reads 70h, bit 7 zero.
// - Diagnostic bits per channel 00h, channel count 02h.
// - Lost-edge byte: bit 0 input zero, bit 1 input one.
// - Diagnostic record ends with full 32-bit ticker at the event.
// - First four diagnostic bytes readable alone by a separate record.
// - Rising enable byte: bit 0 input zero, bit 1 input one.
// - Diagnostic interrupts off at 00h, on at 40h.
`timescale 1ns/1ps
module edid_top (
    input wire logic I_REF_CLK,
    input wire logic I_ARST_N,
    input wire logic [1:0] I_DIN,
    input wire logic I_PRM_WR,
    input wire logic [7:0] I_PRM_REC,
    input wire logic [4:0] I_PRM_IDX,
    input wire logic [7:0] I_PRM_DATA,
    input wire logic I_RD,
    input wire logic [7:0] I_RD_REC,
    input wire logic [4:0] I_RD_IDX,
    input wire logic I_PIRQ_ACK,
    input wire logic I_DIAG_ACK,
    output logic [7:0] O_RD_DATA,
    output logic O_RD_VALID,
    output logic O_RD_ERR,
    output logic O_PIRQ,
    output logic O_DIAG_IRQ,
    output logic O_MODULE_FAULT_INDICATOR
);
    localparam int NC = edid_pkg::NUM_CH;

    logic [NC-1:0] din_m_r;
    logic [NC-1:0] din_s_r;
    logic [NC-1:0] din_p_r;
    logic [NC-1:0] rise_hit;
    logic [NC-1:0] fall_hit;
    logic [NC-1:0] edge_hit;
    logic [4:0] pre_r;
    logic [31:0] ticker_r;
    logic [7:0] diag_irq_enable_r;
    logic [7:0] rising_edge_irq_enable_r;
    logic [7:0] falling_edge_irq_enable_r;
    logic [7:0] irq_edge_flags_r;
    logic [7:0] irq_input_levels_r;
    logic [15:0] irq_timestamp_low_r;
    logic pirq_r;
    logic lost_cond;
    logic diag_active_r;
    logic diag_pend_r;
    logic ovf_r;
    logic [7:0] diag_flags_primary_r;
    logic [7:0] diag_flags_secondary_r;
    logic [7:0] lost_edge_flags_r;
    logic [31:0] diag_timestamp_r;
    logic incoming;
    logic going;
    logic diag_evt;
    logic diag_irq_enable;
    logic [2:0] arm_r;
    logic pirq_take;
    logic ovf_set;
    logic buf_ovf_r;
    logic [7:0] sec_flags;

    // Two stages before any logic looks at the pins
    always_ff @(posedge I_REF_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            din_m_r <= '0;
            din_s_r <= '0;
            din_p_r <= '0;
        end
        else
        begin
            din_m_r <= I_DIN;
            din_s_r <= din_m_r;
            din_p_r <= din_s_r;
        end
    end

    // Edges count only once the pipe holds real pin levels; a pin
    // already high at reset would otherwise pass for a rising edge
    always_ff @(posedge I_REF_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
            arm_r <= '0;
        else
            arm_r <= {arm_r[1:0], 1'b1};
    end

    genvar g;
    generate
        for (g = 0; g < NC; g++)
        begin : g_edge
            assign rise_hit[g] = din_s_r[g] & ~din_p_r[g]
                & rising_edge_irq_enable_r[g];
            assign fall_hit[g] = ~din_s_r[g] & din_p_r[g]
                & falling_edge_irq_enable_r[g];
            assign edge_hit[g] = (rise_hit[g] | fall_hit[g]) & arm_r[2];
        end
    endgenerate

    // Microsecond ticker, free running from reset
    always_ff @(posedge I_REF_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            pre_r <= '0;
            ticker_r <= '0;
        end
        else if (pre_r == 5'(edid_pkg::TICK_CYC - 1))
        begin
            pre_r <= '0;
            ticker_r <= ticker_r + 32'h0000_0001;
        end
        else
        begin
            pre_r <= pre_r + 5'h01;
        end
    end

    // Parameter records
    always_ff @(posedge I_REF_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            diag_irq_enable_r <= edid_pkg::DIAG_IRQ_ENABLE_RST;
            rising_edge_irq_enable_r <= edid_pkg::EDGE_EN_RST;
            falling_edge_irq_enable_r <= edid_pkg::EDGE_EN_RST;
        end
        else if (I_PRM_WR)
        begin
            if (I_PRM_REC == edid_pkg::REC_DIAG_IRQ_ENABLE)
                diag_irq_enable_r <= I_PRM_DATA;
            else if (I_PRM_REC == edid_pkg::REC_EDGE_EN)
            begin
                // Reserved enable bits are not kept
                if (I_PRM_IDX == edid_pkg::IDX_RISE_EN)
                    rising_edge_irq_enable_r <= {6'h00, I_PRM_DATA[1:0]};
                else if (I_PRM_IDX == edid_pkg::IDX_FALL_EN)
                    falling_edge_irq_enable_r <= {6'h00, I_PRM_DATA[1:0]};
            end
        end
    end

    // Ack and new edge in one cycle: the new edge wins
    assign pirq_take = |edge_hit && (!pirq_r || I_PIRQ_ACK);

    // Process interrupt: one record slot, held until acknowledged
    always_ff @(posedge I_REF_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
            pirq_r <= 1'b0;
        else if (pirq_take)
            pirq_r <= 1'b1;
        else if (I_PIRQ_ACK)
            pirq_r <= 1'b0;
    end

    // Record of the accepted edge, every field from one cycle
    always_ff @(posedge I_REF_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            irq_edge_flags_r <= '0;
            irq_input_levels_r <= '0;
            irq_timestamp_low_r <= '0;
        end
        else if (pirq_take)
        begin
            irq_edge_flags_r <= {6'h00, edge_hit};
            irq_input_levels_r <= {6'h00, din_s_r};
            irq_timestamp_low_r <= ticker_r[15:0];
        end
    end

    // Lost while the slot is full; the cause lasts until the ack
    assign lost_cond = |edge_hit && pirq_r && !I_PIRQ_ACK;
    // Any value but the enable code leaves diagnostic interrupts off
    assign diag_irq_enable = (diag_irq_enable_r == edid_pkg::DIAG_IRQ_ENABLE_ON);
    assign incoming = lost_cond && !diag_active_r;
    assign going = diag_active_r && (!pirq_r || I_PIRQ_ACK);
    assign diag_evt = incoming || going;
    // A new event while the last one is unacknowledged overflows
    assign ovf_set = diag_evt && diag_pend_r && !I_DIAG_ACK;
    assign sec_flags = diag_flags_secondary_r
        | (8'(buf_ovf_r) << edid_pkg::FS_BUF_OVF);

    // Fault span: first incoming to last going
    always_ff @(posedge I_REF_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
            diag_active_r <= 1'b0;
        else if (incoming)
            diag_active_r <= 1'b1;
        else if (going)
            diag_active_r <= 1'b0;
    end

    // Overflow flag, cleared by an ack that meets no new event
    always_ff @(posedge I_REF_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
            buf_ovf_r <= 1'b0;
        else if (ovf_set)
            buf_ovf_r <= 1'b1;
        else if (I_DIAG_ACK && !diag_evt)
            buf_ovf_r <= 1'b0;
    end

    // Diagnostic state and record; later losses are dropped meanwhile
    always_ff @(posedge I_REF_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            diag_flags_primary_r <= '0;
            diag_flags_secondary_r <= '0;
            lost_edge_flags_r <= '0;
            diag_timestamp_r <= '0;
        end
        else if (incoming)
        begin
            diag_flags_primary_r <= '0;
            diag_flags_primary_r[edid_pkg::FP_CH_ERR] <= 1'b1;
            diag_flags_secondary_r[edid_pkg::FS_PIRQ_LOST] <= 1'b1;
            lost_edge_flags_r <= {6'h00, edge_hit};
            diag_timestamp_r <= ticker_r;
        end
        else if (going)
        begin
            diag_flags_primary_r <= '0;
            diag_flags_secondary_r[edid_pkg::FS_PIRQ_LOST] <= 1'b0;
            lost_edge_flags_r <= '0;
            diag_timestamp_r <= ticker_r;
        end
        // No branch for lost_cond while active: discarded
    end

    // Diagnostic interrupt line; overflow raises it whatever the enable
    always_ff @(posedge I_REF_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            diag_pend_r <= 1'b0;
            ovf_r <= 1'b0;
        end
        else
        begin
            ovf_r <= ovf_set;
            if (diag_evt && (diag_irq_enable || diag_pend_r))
                diag_pend_r <= 1'b1;
            else if (ovf_r)
                diag_pend_r <= 1'b1;
            else if (I_DIAG_ACK)
                diag_pend_r <= 1'b0;
        end
    end

    function automatic logic [7:0] ts_byte(input logic [31:0] ts,
                                           input logic [1:0] pos);
        ts_byte = ts[8*(3-pos) +: 8];
    endfunction : ts_byte

    function automatic logic [7:0] diag_byte(input logic [4:0] idx,
                                             input logic [7:0] pri,
                                             input logic [7:0] sec,
                                             input logic [7:0] lost,
                                             input logic [31:0] ts);
        case (idx)
            edid_pkg::DB_FLAGS_PRI: diag_byte = pri;
            edid_pkg::DB_MOD_INFO: diag_byte = edid_pkg::MOD_INFO_VAL;
            edid_pkg::DB_FLAGS_SEC: diag_byte = sec;
            edid_pkg::DB_CH_KIND: diag_byte = edid_pkg::CH_KIND_VAL;
            edid_pkg::DB_BITS_PER_CH: diag_byte = edid_pkg::BITS_PER_CH_VAL;
            edid_pkg::DB_CH_COUNT: diag_byte = edid_pkg::CH_COUNT_VAL;
            edid_pkg::DB_LOST: diag_byte = lost;
            default:
                if (idx >= edid_pkg::DB_TS)
                    diag_byte = ts_byte(ts, idx[1:0]);
                else
                    diag_byte = edid_pkg::BYTE_ZERO;
        endcase
    endfunction : diag_byte

    // Record read port, answer one cycle after the strobe
    always_ff @(posedge I_REF_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            O_RD_DATA <= '0;
            O_RD_VALID <= 1'b0;
            O_RD_ERR <= 1'b0;
        end
        else
        begin
            O_RD_VALID <= I_RD;
            O_RD_ERR <= 1'b0;
            O_RD_DATA <= edid_pkg::BYTE_ZERO;
            if (I_RD)
            begin
                if (I_RD_REC == edid_pkg::REC_DIAG_FULL
                    && I_RD_IDX < edid_pkg::LEN_DIAG_FULL)
                    O_RD_DATA <= diag_byte(I_RD_IDX, diag_flags_primary_r,
                        sec_flags, lost_edge_flags_r,
                        diag_timestamp_r);
                else if (I_RD_REC == edid_pkg::REC_DIAG_SHORT
                    && I_RD_IDX < edid_pkg::LEN_DIAG_SHORT)
                    O_RD_DATA <= diag_byte(I_RD_IDX, diag_flags_primary_r,
                        sec_flags, lost_edge_flags_r,
                        diag_timestamp_r);
                else if (I_RD_REC == edid_pkg::REC_PIRQ
                    && I_RD_IDX < edid_pkg::LEN_PIRQ)
                begin
                    case (I_RD_IDX)
                        edid_pkg::PB_EDGES: O_RD_DATA <= irq_edge_flags_r;
                        edid_pkg::PB_LEVELS: O_RD_DATA <= irq_input_levels_r;
                        edid_pkg::PB_TS_HI:
                            O_RD_DATA <= irq_timestamp_low_r[15:8];
                        default: O_RD_DATA <= irq_timestamp_low_r[7:0];
                    endcase
                end
                else
                    O_RD_ERR <= 1'b1;
            end
        end
    end

    // Pending process interrupt to the host
    always_ff @(posedge I_REF_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
            O_PIRQ <= 1'b0;
        else
            O_PIRQ <= pirq_r;
    end

    // Pending diagnostic interrupt to the host
    always_ff @(posedge I_REF_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
            O_DIAG_IRQ <= 1'b0;
        else
            O_DIAG_IRQ <= diag_pend_r;
    end

    // Indicator spans incoming to going
    always_ff @(posedge I_REF_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
            O_MODULE_FAULT_INDICATOR <= 1'b0;
        else
            O_MODULE_FAULT_INDICATOR <= diag_active_r;
    end
endmodule : edid_top

// >>> verif/edid_chk.sv
// Port checker of the edge interrupt and diagnostic block
`timescale 1ns/1ps
module edid_chk (
    input wire logic I_REF_CLK,
    input wire logic I_ARST_N,
    input wire logic [1:0] I_DIN,
    input wire logic I_RD,
    input wire logic [7:0] I_RD_REC,
    input wire logic [4:0] I_RD_IDX,
    input wire logic I_PIRQ_ACK,
    input wire logic [7:0] O_RD_DATA,
    input wire logic O_RD_VALID,
    input wire logic O_RD_ERR,
    input wire logic O_PIRQ,
    input wire logic O_DIAG_IRQ,
    input wire logic O_MODULE_FAULT_INDICATOR
);
    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (!I_ARST_N);
    logic [1:0] din_r;
    logic [3:0] chg_r;
    logic [3:0] ack_r;
    logic diag_rd;
    assign diag_rd = I_RD && I_RD_REC == edid_pkg::REC_DIAG_FULL;
    // Age of the last pin change, saturating
    always_ff @(posedge I_REF_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            din_r <= 2'h0;
            chg_r <= 4'hF;
        end
        else
        begin
            din_r <= I_DIN;
            chg_r <= (I_DIN != din_r) ? 4'h0 : chg_r + {3'h0, chg_r != 4'hF};
        end
    end
    // Age of the last process interrupt ack, saturating
    always_ff @(posedge I_REF_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
            ack_r <= 4'hF;
        else
            ack_r <= I_PIRQ_ACK ? 4'h0 : ack_r + {3'h0, ack_r != 4'hF};
    end
    rd_answer_a: assert property (I_RD |=> O_RD_VALID)
        else $error("read not answered next cycle");
    rd_err_a: assert property (O_RD_ERR |-> O_RD_VALID && O_RD_DATA == 8'h00)
        else $error("refused read carries data");
    bad_index_a: assert property (diag_rd && I_RD_IDX >= edid_pkg::LEN_DIAG_FULL
        |=> O_RD_ERR)
        else $error("index past record not refused");
    mod_info_a: assert property (diag_rd && I_RD_IDX == 5'h01
        |=> O_RD_DATA == 8'h1F)
        else $error("module info byte wrong");
    ch_kind_a: assert property (diag_rd && I_RD_IDX == 5'h04
        |=> O_RD_DATA == 8'h70)
        else $error("channel kind byte wrong");
    ch_count_a: assert property (diag_rd && I_RD_IDX == 5'h06
        |=> O_RD_DATA == 8'h02)
        else $error("channel count byte wrong");
    rsvd_bytes_a: assert property (diag_rd && I_RD_IDX inside {[5'h08:5'h0F]}
        |=> O_RD_DATA == 8'h00)
        else $error("reserved byte not zero");
    pirq_cause_a: assert property ($rose(O_PIRQ) |-> chg_r inside {[4'h1:4'h8]})
        else $error("process interrupt without pin edge");
    pirq_hold_a: assert property (O_PIRQ && !I_PIRQ_ACK && !$past(I_PIRQ_ACK)
        |=> O_PIRQ)
        else $error("process interrupt dropped without ack");
    fault_rise_a: assert property ($rose(O_MODULE_FAULT_INDICATOR) |-> O_PIRQ)
        else $error("fault lit without pending interrupt");
    fault_fall_a: assert property ($fell(O_MODULE_FAULT_INDICATOR)
        |-> ack_r <= 4'h5)
        else $error("fault cleared without ack");
    cover property ($rose(O_PIRQ));
    cover property ($rose(O_MODULE_FAULT_INDICATOR));
    cover property ($rose(O_DIAG_IRQ));
endmodule : edid_chk

bind edid_top edid_chk u_edid_chk (.I_REF_CLK, .I_ARST_N, .I_DIN, .I_RD,
    .I_RD_REC, .I_RD_IDX, .I_PIRQ_ACK, .O_RD_DATA, .O_RD_VALID, .O_RD_ERR,
    .O_PIRQ, .O_DIAG_IRQ, .O_MODULE_FAULT_INDICATOR);

// >>> verif/edid_host.sv
// Backplane host model: parameter writes, record reads and acks
`timescale 1ns/1ps
module edid_host (
    input wire logic i_clk,
    input wire logic [7:0] i_rd_data,
    input wire logic i_rd_valid,
    input wire logic i_rd_err,
    output logic o_prm_wr = 1'b0,
    output logic [7:0] o_prm_rec = 8'h00,
    output logic [4:0] o_prm_idx = 5'h00,
    output logic [7:0] o_prm_data = 8'h00,
    output logic o_rd = 1'b0,
    output logic [7:0] o_rd_rec = 8'h00,
    output logic [4:0] o_rd_idx = 5'h00,
    output logic o_pirq_ack = 1'b0,
    output logic o_diag_ack = 1'b0
);
    task automatic wr(input logic [7:0] rec, input logic [4:0] idx,
        input logic [7:0] data);
        @(posedge i_clk);
        o_prm_wr <= 1'b1;
        o_prm_rec <= rec;
        o_prm_idx <= idx;
        o_prm_data <= data;
        @(posedge i_clk);
        o_prm_wr <= 1'b0;
        // Released data line must not keep the last value
        o_prm_data <= ~data;
    endtask : wr

    task automatic rd(input logic [7:0] rec, input logic [4:0] idx,
        output logic [7:0] data, output logic err);
        @(posedge i_clk);
        o_rd <= 1'b1;
        o_rd_rec <= rec;
        o_rd_idx <= idx;
        @(posedge i_clk);
        o_rd <= 1'b0;
        o_rd_idx <= ~idx;
        #1;
        data = i_rd_valid ? i_rd_data : 8'hXX;
        err = i_rd_err;
    endtask : rd

    // Gap lets the host answer late as well as promptly
    task automatic ack(input logic diag, input logic [1:0] gap);
        repeat (gap) @(posedge i_clk);
        @(posedge i_clk);
        if (diag)
            o_diag_ack <= 1'b1;
        else
            o_pirq_ack <= 1'b1;
        @(posedge i_clk);
        o_diag_ack <= 1'b0;
        o_pirq_ack <= 1'b0;
    endtask : ack
endmodule : edid_host

// >>> verif/test_edge_interrupt_diagnostics.sv
// Self-checking bench of the edge interrupt and diagnostic block
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fail_count++; \
    $display("BAD %0t got %h want %h", $time, g, e); end end
module test_edge_interrupt_diagnostics;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [1:0] din = 2'h0;
    logic prm_wr, rd, pack, dack, vld, err, pirq, dirq, fault, e, ch;
    logic [7:0] prec, pdat, rrec, rdat, d;
    logic [4:0] pidx, ridx;
    logic [15:0] tsv;
    logic [31:0] lfsr_r, ts;
    int fail_count = 0;
    int compares = 0;
    int cyc = 0;
    int t0 = 0;
    edid_top u_edid_top (.I_REF_CLK(clk), .I_ARST_N(arst_n), .I_DIN(din),
        .I_PRM_WR(prm_wr), .I_PRM_REC(prec), .I_PRM_IDX(pidx),
        .I_PRM_DATA(pdat), .I_RD(rd), .I_RD_REC(rrec), .I_RD_IDX(ridx),
        .I_PIRQ_ACK(pack), .I_DIAG_ACK(dack), .O_RD_DATA(rdat),
        .O_RD_VALID(vld), .O_RD_ERR(err), .O_PIRQ(pirq), .O_DIAG_IRQ(dirq),
        .O_MODULE_FAULT_INDICATOR(fault));
    edid_host u_edid_host (.i_clk(clk), .i_rd_data(rdat), .i_rd_valid(vld),
        .i_rd_err(err), .o_prm_wr(prm_wr), .o_prm_rec(prec),
        .o_prm_idx(pidx), .o_prm_data(pdat), .o_rd(rd), .o_rd_rec(rrec),
        .o_rd_idx(ridx), .o_pirq_ack(pack), .o_diag_ack(dack));
    always #20 clk = ~clk;
    always @(posedge clk)
        if (arst_n)
            cyc <= cyc + 1;

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    function automatic logic [7:0] exp_diag(input logic [4:0] i,
        input logic [7:0] pri);
        case (i)
            5'h00: return pri;
            5'h01: return 8'h1F;
            5'h04: return 8'h70;
            5'h06: return 8'h02;
            default: return 8'h00;
        endcase
    endfunction : exp_diag

    task automatic rdb(input logic [7:0] rec, input logic [4:0] idx);
        u_edid_host.rd(rec, idx, d, e);
    endtask : rdb

    task automatic flip(input logic c);
        @(posedge clk);
        din[c] <= ~din[c];
        t0 = cyc;
        repeat (10) @(posedge clk);
        #1;
    endtask : flip

    task automatic end_of_test();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_of_test

    initial
    begin
        #800000;
        fail_count++;
        end_of_test();
    end

    initial
    begin
        lfsr_r = 32'h2593F0DC;
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        for (int i = 0; i < 20; i++)
        begin
            rdb(edid_pkg::REC_DIAG_FULL, 5'(i));
            `CHK(d, exp_diag(5'(i), 8'h00))
            if (i < 4)
            begin
                rdb(edid_pkg::REC_DIAG_SHORT, 5'(i));
                `CHK(d, exp_diag(5'(i), 8'h00))
            end
        end
        rdb(edid_pkg::REC_DIAG_SHORT, 5'h04);
        `CHK(e, 1'b1)
        rdb(edid_pkg::REC_DIAG_FULL, 5'h14);
        `CHK(e, 1'b1)
        rdb(8'h03, lfsr_r[4:0]);
        `CHK(e, 1'b1)
        `CHK(d, 8'h00)
        for (int s = 0; s < 4; s++)
        begin
            u_edid_host.wr(edid_pkg::REC_EDGE_EN, 5'h00, 8'(s));
            u_edid_host.wr(edid_pkg::REC_EDGE_EN, 5'h01, 8'(3 - s));
            for (int k = 0; k < 6; k++)
            begin
                lfsr_r = lfsr_next(lfsr_r);
                ch = lfsr_r[0];
                flip(ch);
                `CHK(pirq, din[ch] ? s[ch] : ~s[ch])
                if (pirq === 1'b1)
                begin
                    rdb(edid_pkg::REC_PIRQ, 5'h00);
                    `CHK(d, 8'h01 << ch)
                    rdb(edid_pkg::REC_PIRQ, 5'h01);
                    `CHK(d, {6'h00, din})
                    rdb(edid_pkg::REC_PIRQ, 5'h02);
                    tsv[15:8] = d;
                    rdb(edid_pkg::REC_PIRQ, 5'h03);
                    tsv[7:0] = d;
                    `CHK(tsv - 16'((t0 + 4) / 25) + 16'h1 <= 16'h2, 1'b1)
                    u_edid_host.ack(1'b0, lfsr_r[2:1]);
                    repeat (3) @(posedge clk);
                    `CHK(pirq, 1'b0)
                end
            end
        end
        u_edid_host.wr(edid_pkg::REC_EDGE_EN, 5'h00, 8'h03);
        u_edid_host.wr(edid_pkg::REC_EDGE_EN, 5'h01, 8'h03);
        for (int m = 0; m < 2; m++)
        begin
            u_edid_host.wr(edid_pkg::REC_DIAG_IRQ_ENABLE, 5'h00, m ? 8'h00 : 8'h40);
            flip(1'b0);
            flip(1'b1);
            `CHK(fault, 1'b1)
            `CHK(dirq, m == 0)
            rdb(edid_pkg::REC_DIAG_FULL, 5'h00);
            `CHK(d, 8'h08)
            rdb(edid_pkg::REC_DIAG_FULL, 5'h03);
            `CHK(d & 8'h40, 8'h40)
            rdb(edid_pkg::REC_DIAG_SHORT, 5'h00);
            `CHK(d, 8'h08)
            for (int i = 16; i < 20; i++)
            begin
                rdb(edid_pkg::REC_DIAG_FULL, 5'(i));
                ts = {ts[23:0], d};
            end
            `CHK(ts - 32'((t0 + 4) / 25) + 32'h1 <= 32'h2, 1'b1)
            flip(1'b0);
            rdb(edid_pkg::REC_DIAG_FULL, 5'h07);
            `CHK(d, 8'h02)
            u_edid_host.ack(1'b0, 2'h0);
            repeat (6) @(posedge clk);
            `CHK(fault, 1'b0)
            rdb(edid_pkg::REC_DIAG_FULL, 5'h03);
            `CHK(d & 8'h08, m ? 8'h00 : 8'h08)
            u_edid_host.ack(1'b1, 2'h1);
            repeat (4) @(posedge clk);
            `CHK(dirq, 1'b0)
        end
        end_of_test();
    end
endmodule : test_edge_interrupt_diagnostics
